//--- bench/ibs_bus_master.sv
// behavioural bus controller on the far side of the two wires
`default_nettype none
module ibs_bus_master #(
  parameter int HALF = 20
) (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var  logic scl_oe,
  output var  logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int hung = 0;
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(posedge clk);
    #1;
  endtask
  // a stretching slave holds scl low; bounded so a stuck stretch is caught
  task automatic rise();
    int n;
    n = 0;
    scl_oe = 1'b0;
    while (scl !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
      hung++;
    half();
  endtask
  task automatic bit_out(input logic b);
    sda_oe = !b;
    half();
    rise();
    scl_oe = 1'b1;
  endtask
  task automatic bit_in(output logic b);
    sda_oe = 1'b0;
    half();
    rise();
    b = sda;
    scl_oe = 1'b1;
  endtask
  task automatic bits(input logic [7:0] d, input int n);
    for (int i = 7; i > 7 - n; i--)
      bit_out(d[i]);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    bits(d, 8);
    bit_in(ack);
  endtask
  task automatic recv(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(nack);
  endtask
  task automatic start();
    sda_oe = 1'b0;
    half();
    rise();
    sda_oe = 1'b1;
    half();
    scl_oe = 1'b1;
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    half();
    rise();
    sda_oe = 1'b0;
    half();
  endtask
endmodule // ibs_bus_master
`default_nettype wire

//--- bench/ibs_core_asserts.sv
// concurrent checks on the ports of the core: slave path, controller role and flags
`default_nettype none
module ibs_core_asserts (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PE,
  input wire logic SR1_RD,
  input wire logic SR2_RD,
  input wire logic RXD_RD,
  input wire logic TXD_WR,
  input wire logic IRQ_ENABLE,
  input wire logic BUS_IRQ_MASK,
  input wire logic SDA_OE,
  input wire logic SCL_OE,
  input wire logic EVENT_PENDING,
  input wire logic OWN_ADDRESS_HIT,
  input wire logic BYTE_DONE_FLAG,
  input wire logic STOP_SEEN_FLAG,
  input wire logic MISPLACED_CONDITION_ERROR,
  input wire logic NACK_SEEN_FLAG,
  input wire logic CONTROLLER_ROLE_BIT,
  input wire logic TRANSMIT_ROLE,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // helpers
  // ******
  logic rx_seen_r;
  logic tx_seen_r;
  wire  any_flag = OWN_ADDRESS_HIT | BYTE_DONE_FLAG | STOP_SEEN_FLAG
                 | MISPLACED_CONDITION_ERROR | NACK_SEEN_FLAG;
  // strobes only count once a stretch is visible on the pin
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      rx_seen_r <= 1'b0;
      tx_seen_r <= 1'b0;
    end
    else
    begin
      rx_seen_r <= SCL_OE & (rx_seen_r | RXD_RD);
      tx_seen_r <= SCL_OE & (tx_seen_r | TXD_WR);
    end
  // ******
  // properties
  // ******
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  role_start_a: assert property ($rose(CONTROLLER_ROLE_BIT) |-> SDA_OE)
    else $error("controller role without a start");
  hit_stretch_a: assert property ($rose(OWN_ADDRESS_HIT) |-> ##[0:2] SCL_OE)
    else $error("address hit without clock stretch");
  hit_sticky_a: assert property (OWN_ADDRESS_HIT && !SR1_RD && PE |=> OWN_ADDRESS_HIT)
    else $error("address hit lost before status read");
  rx_hold_a: assert property (BYTE_DONE_FLAG && !TRANSMIT_ROLE && SCL_OE
    && !rx_seen_r && !RXD_RD |=> SCL_OE) else $error("rx stretch left early");
  tx_hold_a: assert property (TRANSMIT_ROLE && !CONTROLLER_ROLE_BIT && SCL_OE
    && !tx_seen_r && !TXD_WR |=> SCL_OE) else $error("tx stretch left early");
  nack_free_a: assert property ($rose(NACK_SEEN_FLAG) |-> !SCL_OE [*8])
    else $error("clock stretched after nack");
  misplaced_condition_error_free_a: assert property ($rose(MISPLACED_CONDITION_ERROR)
    |-> ##1 (!SCL_OE && !SDA_OE) [*4]) else $error("lines held after bus error");
  stop_sticky_a: assert property (STOP_SEEN_FLAG && !SR2_RD && PE |=> STOP_SEEN_FLAG)
    else $error("stop flag lost before read");
  event_set_a: assert property (any_flag |-> ##[0:1] EVENT_PENDING)
    else $error("event not raised with a flag");
  irq_gate_a: assert property (IRQ |-> $past(IRQ_ENABLE && BUS_IRQ_MASK))
    else $error("interrupt while disabled");
  cover property ($rose(BYTE_DONE_FLAG) && TRANSMIT_ROLE);
  cover property ($rose(NACK_SEEN_FLAG));
  cover property ($rose(MISPLACED_CONDITION_ERROR));
endmodule // ibs_core_asserts
`default_nettype wire

//--- bench/test_ibs_core.sv
// self-checking bench: random and corner transfers through a bus controller model
`default_nettype none
module test_ibs_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, pe, gce, acke, fast, a10, start_req, stop_req, ien, msk;
  logic        sr1, sr2, rxd_rd, txd_wr, sda_oe, scl_oe, ack;
  logic        ev, hit, bdf, stop_seen_flag, misplaced_condition_error, nackf, role, txr, gch, busy, irq;
  logic [9:0]  own;
  logic [7:0]  txd, rxd, d, r, a;
  logic [31:0] seed = 32'h0001020E;
  int          mismatches = 0;
  int          compares = 0;
  wire         m_scl, m_sda;
  wire         scl = !(scl_oe || m_scl);
  wire         sda = !(sda_oe || m_sda);
  ibs_core dut (.CLK(clk), .NRST(nrst), .CE(1'b1), .PE(pe), .SDA_IN(sda), .SCL_IN(scl),
    .SDA_OUT(), .SDA_OE(sda_oe), .SCL_OUT(), .SCL_OE(scl_oe), .OWN_ADDR(own),
    .ADDR10_MODE(a10), .GENERAL_CALL_ENABLE(gce), .ACK_ENABLE(acke), .FAST_MODE(fast),
    .STD_DIVIDER(16'h0004), .FAST_DIVIDER(16'h0004), .START_REQ(start_req),
    .STOP_REQ(stop_req), .IRQ_ENABLE(ien), .BUS_IRQ_MASK(msk), .SR1_RD(sr1), .SR2_RD(sr2),
    .RXD_RD(rxd_rd), .TXD_WR(txd_wr), .TXD_DATA(txd), .RXD_DATA(rxd), .EVENT_PENDING(ev),
    .OWN_ADDRESS_HIT(hit), .BYTE_DONE_FLAG(bdf), .STOP_SEEN_FLAG(stop_seen_flag),
    .MISPLACED_CONDITION_ERROR(misplaced_condition_error), .NACK_SEEN_FLAG(nackf), .CONTROLLER_ROLE_BIT(role),
    .TRANSMIT_ROLE(txr), .GENERAL_CALL_HIT(gch), .BUS_BUSY(busy), .IRQ(irq));
  ibs_bus_master m (.clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ******
  // helpers
  // ******
  task automatic end_of_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic hit_exp(input logic [7:0] x);
    return (x[7:1] == own[6:0]) || (x == 8'h00 && gce);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    tick(1);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic addr_w(input logic rw);
    m.start();
    m.send({own[6:0], rw}, ack);
    tick(8);
    chk(hit, 1'b1);
    pulse(sr1);
  endtask
  task automatic wait_role(input logic v);
    int n;
    n = 0;
    while (role !== v && n < 1000)
    begin
      tick(1);
      n++;
    end
    chk(role, v);
    if (n >= 1000)
      end_of_test();
  endtask
  always @(posedge clk)
    if (m.hung != 0)
    begin
      mismatches++;
      end_of_test();
    end
  // ******
  // scenarios
  // ******
  initial
  begin
    {nrst, pe, gce, acke, fast, a10, start_req, stop_req, ien, msk} = 10'h000;
    {sr1, sr2, rxd_rd, txd_wr, own, txd} = 22'h000000;
    tick(8);
    nrst = 1'b1;
    tick(2);
    pe = 1'b1;
    d = rnd();
    own = {3'h0, 1'b1, d[5:0]};
    chk(role, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      d = rnd();
      {ien, msk} = (i == 0) ? 2'b11 : d[1:0];
      gce = (i >= 3);
      acke = (i != 5);
      a = (i == 2 || i == 3) ? 8'h00 : (i == 4) ? 8'h01 : {own[6:0] ^ {6'h00, i == 1}, 1'b0};
      m.start();
      m.send(a, ack);
      tick(8);
      chk(ack, !(hit_exp(a) && acke));
      chk(hit, hit_exp(a));
      // an ignored 01h keeps the indication of the general call before it
      chk(gch, gce && a[7:1] == 7'h00);
      chk(ev, hit_exp(a));
      chk(irq, hit_exp(a) && ien && msk);
      pulse(sr1);
      m.stop();
      tick(8);
      chk(stop_seen_flag, hit_exp(a));
      pulse(sr2);
    end
    acke = 1'b1;
    addr_w(1'b0);
    for (int k = 0; k < 3; k++)
    begin
      d = rnd();
      m.send(d, ack);
      tick(48);
      chk({ack, bdf, scl_oe}, 3'b011);
      chk(rxd, d);
      if (d[0])
        pulse(rxd_rd);
      pulse(sr1);
      if (!d[0])
        pulse(rxd_rd);
      tick(8);
      chk(bdf, 1'b0);
    end
    m.stop();
    tick(8);
    chk(stop_seen_flag, 1'b1);
    pulse(sr2);
    tick(2);
    chk(stop_seen_flag, 1'b0);
    addr_w(1'b1);
    for (int k = 0; k < 2; k++)
    begin
      d = rnd();
      tick(40);
      chk(scl_oe, 1'b1);
      txd = d;
      pulse(txd_wr);
      m.recv(k == 1, r);
      tick(8);
      chk(r, d);
      chk({txr, k ? nackf : bdf}, {k == 0, 1'b1});
      pulse(sr1);
    end
    chk(scl_oe, 1'b0);
    m.stop();
    tick(8);
    pulse(sr2);
    tick(2);
    chk(ev, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      addr_w(1'b0);
      m.bits(rnd(), 3);
      if (j)
        addr_w(1'b0);
      m.stop();
      tick(8);
      chk({misplaced_condition_error, scl_oe, sda_oe}, 3'b100);
      pulse(sr2);
    end
    d = rnd();
    own = {d[1:0], d ^ 8'h5A};
    a10 = 1'b1;
    m.start();
    m.send({5'h1E, own[9:8], 1'b0}, ack);
    chk(ack, 1'b0);
    m.send(own[7:0], ack);
    tick(8);
    chk({ack, hit, txr}, 3'b010);
    pulse(sr1);
    m.start();
    m.send({5'h1E, own[9:8], 1'b1}, ack);
    tick(8);
    chk({ack, hit, txr}, 3'b011);
    pulse(sr1);
    txd = d;
    pulse(txd_wr);
    m.recv(1'b1, r);
    chk(r, d);
    m.stop();
    tick(8);
    chk({stop_seen_flag, nackf}, 2'b11);
    pulse(sr2);
    a10 = 1'b0;
    fast = d[7];
    start_req = 1'b1;
    wait_role(1'b1);
    chk(busy, 1'b1);
    start_req = 1'b0;
    stop_req = 1'b1;
    wait_role(1'b0);
    stop_req = 1'b0;
    tick(20);
    end_of_test();
  end
endmodule // test_ibs_core
bind ibs_core ibs_core_asserts u_chk (.CLK, .NRST, .PE, .SR1_RD, .SR2_RD, .RXD_RD, .TXD_WR,
  .IRQ_ENABLE, .BUS_IRQ_MASK, .SDA_OE, .SCL_OE, .EVENT_PENDING, .OWN_ADDRESS_HIT,
  .BYTE_DONE_FLAG, .STOP_SEEN_FLAG, .MISPLACED_CONDITION_ERROR, .NACK_SEEN_FLAG,
  .CONTROLLER_ROLE_BIT, .TRANSMIT_ROLE, .IRQ);
`default_nettype wire

//--- hw/ibs_core.v
// two-wire bus interface: slave path, start/stop generation and flags
`default_nettype none
`include "ibs_regs.vh"
module ibs_core #(
  parameter DW = 16
) (
  input  wire          CLK,
  input  wire          NRST,
  input  wire          CE,
  input  wire          PE,
  input  wire          SDA_IN,
  input  wire          SCL_IN,
  output reg           SDA_OUT,
  output reg           SDA_OE,
  output reg           SCL_OUT,
  output reg           SCL_OE,
  input  wire [9:0]    OWN_ADDR,
  input  wire          ADDR10_MODE,
  input  wire          GENERAL_CALL_ENABLE,
  input  wire          ACK_ENABLE,
  input  wire          FAST_MODE,
  input  wire [DW-1:0] STD_DIVIDER,
  input  wire [DW-1:0] FAST_DIVIDER,
  input  wire          START_REQ,
  input  wire          STOP_REQ,
  input  wire          IRQ_ENABLE,
  input  wire          BUS_IRQ_MASK,
  input  wire          SR1_RD,
  input  wire          SR2_RD,
  input  wire          RXD_RD,
  input  wire          TXD_WR,
  input  wire [7:0]    TXD_DATA,
  output reg  [7:0]    RXD_DATA,
  output reg           EVENT_PENDING,
  output reg           OWN_ADDRESS_HIT,
  output reg           BYTE_DONE_FLAG,
  output reg           STOP_SEEN_FLAG,
  output reg           MISPLACED_CONDITION_ERROR,
  output reg           NACK_SEEN_FLAG,
  output reg           CONTROLLER_ROLE_BIT,
  output reg           TRANSMIT_ROLE,
  output reg           GENERAL_CALL_HIT,
  output reg           BUS_BUSY,
  output reg           IRQ
);
  // ****************************************************************
  // states
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'h0, S_ADDR = 3'h1, S_RX = 3'h2, S_ACK = 3'h3,
                   S_HOLD = 3'h4, S_TX = 3'h5, S_TXACK = 3'h6, S_IGN = 3'h7;
  localparam [1:0] K_HDR = 2'h0, K_ADR = 2'h1, K_RX = 2'h2, K_TXN = 2'h3;
  localparam [2:0] M_IDLE = 3'h0, M_START = 3'h1, M_ON = 3'h2,
                   M_STOP1 = 3'h3, M_STOP2 = 3'h4;

  // ****************************************************************
  // pin synchronisers and bus conditions
  // ****************************************************************
  reg  [1:0] sda_s_r, scl_s_r;
  reg        sda_d_r, scl_d_r;
  wire       sda = sda_s_r[1];
  wire       scl = scl_s_r[1];
  wire       scl_rise = scl & ~scl_d_r;
  wire       scl_fall = ~scl & scl_d_r;
  wire       cond_start = scl & scl_d_r & sda_d_r & ~sda;
  wire       cond_stop  = scl & scl_d_r & ~sda_d_r & sda;

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sda_s_r <= 2'h3;
      scl_s_r <= 2'h3;
      sda_d_r <= 1'b1;
      scl_d_r <= 1'b1;
    end
    else if (CE)
    begin
      sda_s_r <= {sda_s_r[0], SDA_IN};
      scl_s_r <= {scl_s_r[0], SCL_IN};
      sda_d_r <= sda;
      scl_d_r <= scl;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  function is_hdr;
    input [7:0] b;
    input [1:0] hi;
    begin
      is_hdr = (b[7:3] == `IBS_HDR10_PREFIX) && (b[2:1] == hi);
    end
  endfunction

  // ****************************************************************
  // master start/stop generation
  // ****************************************************************
  wire       tick;
  reg  [2:0] mst_r;
  reg        m_sda_low_r, m_scl_low_r;
  reg        stop_req_d_r;
  // arbitration: a foreign Start seen before ours has reached the pin
  wire       arb_lost = (mst_r == M_START) && cond_start && !SDA_OE;

  ibs_scl_div #(.CW(DW)) u_div (
    .clk      (CLK),
    .nrst     (NRST),
    .ce       (CE),
    .run      (mst_r != M_IDLE),
    .fast     (FAST_MODE),
    .div_std  (STD_DIVIDER),
    .div_fast (FAST_DIVIDER),
    .tick     (tick)
  );

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      mst_r       <= M_IDLE;
      m_sda_low_r <= 1'b0;
      m_scl_low_r <= 1'b0;
    end
    else if (CE)
    begin
      if (!PE)
      begin
        mst_r       <= M_IDLE;
        m_sda_low_r <= 1'b0;
        m_scl_low_r <= 1'b0;
      end
      else
        case (mst_r)
          M_IDLE:
            if (START_REQ && !BUS_BUSY)
            begin
              m_sda_low_r <= 1'b1;
              mst_r       <= M_START;
            end
          M_START:
            if (arb_lost)
            begin
              m_sda_low_r <= 1'b0;
              mst_r       <= M_IDLE;
            end
            else if (tick)
            begin
              m_scl_low_r <= 1'b1;
              mst_r       <= M_ON;
            end
          M_ON:
            if (STOP_REQ)
              mst_r <= M_STOP1;
          M_STOP1:
            if (tick)
            begin
              m_scl_low_r <= 1'b0;
              mst_r       <= M_STOP2;
            end
          M_STOP2:
            if (tick)
            begin
              m_sda_low_r <= 1'b0;
              mst_r       <= M_IDLE;
            end
          default:
            mst_r <= M_IDLE;
        endcase
    end
  end

  // ****************************************************************
  // slave sequencer and flags
  // ****************************************************************
  reg  [2:0] sst_r;
  reg  [1:0] kind_r;
  reg  [7:0] sh_r;
  reg  [2:0] cnt_r;
  reg        ack_ph_r, s_sda_low_r, s_scl_low_r, addr2_r, hdr_ok_r, dir_tx_r;
  reg        talked_r, sr1_seen_r, rxd_seen_r, tx_full_r, rel_pend_r;
  reg  [7:0] tx_buf_r;
  wire [7:0] inb = {sh_r[6:0], sda};
  // a condition in the high phase of a new byte's first bit is a boundary, not an error
  wire       mid_byte = ((sst_r == S_ADDR || sst_r == S_RX) && cnt_r > 3'h1) ||
                        (sst_r == S_TX && cnt_r != 3'h0);
  reg        hit_set, btf_set, stp_set, err_set, af_set;
  wire       hold_go = sr1_seen_r &&
                       ((kind_r == K_RX) ? rxd_seen_r : (!dir_tx_r || tx_full_r));

  always @*
  begin
    hit_set = 1'b0;
    btf_set = 1'b0;
    stp_set = 1'b0;
    err_set = 1'b0;
    af_set  = 1'b0;
    if (PE && cond_start && mid_byte)
      err_set = 1'b1;
    if (PE && cond_stop && mid_byte)
      err_set = 1'b1;
    if (PE && cond_stop && !mid_byte && talked_r)
      stp_set = 1'b1;
    if (PE && !cond_start && !cond_stop)
    begin
      if (sst_r == S_ACK && ack_ph_r && scl_fall)
      begin
        hit_set = (kind_r == K_ADR);
        btf_set = (kind_r == K_RX);
      end
      if (sst_r == S_TXACK && scl_rise)
      begin
        btf_set = ~sda;
        af_set  = sda;
      end
    end
  end

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sst_r       <= S_IDLE;
      kind_r      <= K_HDR;
      sh_r        <= `IBS_RESET_BYTE;
      cnt_r       <= 3'h0;
      ack_ph_r    <= 1'b0;
      s_sda_low_r <= 1'b0;
      s_scl_low_r <= 1'b0;
      addr2_r     <= 1'b0;
      hdr_ok_r    <= 1'b0;
      dir_tx_r    <= 1'b0;
      talked_r    <= 1'b0;
      tx_buf_r    <= `IBS_RESET_BYTE;
      RXD_DATA    <= `IBS_RESET_BYTE;
      GENERAL_CALL_HIT <= 1'b0;
    end
    else if (CE)
    begin
      if (!PE || cond_stop || (rel_pend_r && sst_r == S_HOLD))
      begin
        sst_r       <= S_IDLE;
        s_sda_low_r <= 1'b0;
        s_scl_low_r <= 1'b0;
        hdr_ok_r    <= 1'b0;
        talked_r    <= talked_r && PE && !cond_stop;
      end
      else if (cond_start)
      begin
        sst_r       <= S_ADDR;
        cnt_r       <= 3'h0;
        addr2_r     <= 1'b0;
        s_sda_low_r <= 1'b0;
        s_scl_low_r <= 1'b0;
      end
      else
        case (sst_r)
          S_ADDR, S_RX:
            if (scl_rise)
            begin
              sh_r  <= inb;
              cnt_r <= cnt_r + 3'h1;
              if (cnt_r == 3'h7)
              begin
                ack_ph_r <= 1'b0;
                sst_r    <= S_ACK;
                if (sst_r == S_RX)
                begin
                  kind_r   <= K_RX;
                  RXD_DATA <= inb;
                end
                else if (GENERAL_CALL_ENABLE && !addr2_r && inb == `IBS_GEN_CALL_ADDR)
                begin
                  kind_r   <= K_ADR;
                  dir_tx_r <= 1'b0;
                  GENERAL_CALL_HIT <= 1'b1;
                end
                else if (!ADDR10_MODE && inb[7:1] == OWN_ADDR[6:0])
                begin
                  kind_r   <= K_ADR;
                  dir_tx_r <= inb[0];
                  GENERAL_CALL_HIT <= 1'b0;
                end
                else if (ADDR10_MODE && addr2_r && inb == OWN_ADDR[7:0])
                begin
                  kind_r   <= K_ADR;
                  dir_tx_r <= 1'b0;
                  hdr_ok_r <= 1'b1;
                  GENERAL_CALL_HIT <= 1'b0;
                end
                else if (ADDR10_MODE && !addr2_r && is_hdr(inb, OWN_ADDR[9:8]) &&
                         (!inb[0] || hdr_ok_r))
                begin
                  kind_r   <= inb[0] ? K_ADR : K_HDR;
                  dir_tx_r <= inb[0];
                  GENERAL_CALL_HIT <= 1'b0;
                end
                else
                  sst_r <= S_IGN;
              end
            end
          S_ACK:
            if (scl_fall)
            begin
              ack_ph_r    <= 1'b1;
              s_sda_low_r <= !ack_ph_r && ACK_ENABLE;
              if (ack_ph_r)
              begin
                cnt_r <= 3'h0;
                if (kind_r == K_HDR)
                begin
                  addr2_r <= 1'b1;
                  sst_r   <= S_ADDR;
                end
                else
                begin
                  talked_r    <= 1'b1;
                  sst_r       <= S_HOLD;
                  s_scl_low_r <= 1'b1;
                end
              end
            end
          S_HOLD:
            if (hold_go)
            begin
              s_scl_low_r <= 1'b0;
              cnt_r       <= 3'h0;
              if (dir_tx_r)
              begin
                sh_r        <= tx_buf_r;
                s_sda_low_r <= ~tx_buf_r[7];
                sst_r       <= S_TX;
              end
              else
                sst_r <= S_RX;
            end
          S_TX:
            if (scl_fall)
            begin
              cnt_r       <= cnt_r + 3'h1;
              sh_r        <= {sh_r[6:0], 1'b0};
              s_sda_low_r <= (cnt_r != 3'h7) && ~sh_r[6];
              if (cnt_r == 3'h7)
                sst_r <= S_TXACK;
            end
          S_TXACK:
            if (scl_rise && sda)
              sst_r <= S_IGN;
            else if (scl_fall)
            begin
              kind_r      <= K_TXN;
              sst_r       <= S_HOLD;
              s_scl_low_r <= 1'b1;
            end
          S_IGN:
            s_sda_low_r <= 1'b0;
          default:
            sst_r <= S_IDLE;
        endcase
      if (TXD_WR)
        tx_buf_r <= TXD_DATA;
    end
  end

  // ****************************************************************
  // handshake tracking, flags and pins
  // ****************************************************************
  wire enter_hold = (sst_r == S_ACK && ack_ph_r && scl_fall && kind_r != K_HDR) ||
                    (sst_r == S_TXACK && scl_fall && !scl_rise);
  wire leave_hold = (sst_r == S_HOLD) && hold_go;
  wire adr_nxt = hit_set | (OWN_ADDRESS_HIT & ~SR1_RD);
  wire btf_nxt = btf_set | (BYTE_DONE_FLAG & ~(leave_hold & kind_r != K_ADR));
  wire stp_nxt = stp_set | (STOP_SEEN_FLAG & ~SR2_RD);
  wire err_nxt = err_set | (MISPLACED_CONDITION_ERROR & ~SR2_RD);
  wire af_nxt  = af_set  | (NACK_SEEN_FLAG & ~SR2_RD);
  wire evt_nxt = adr_nxt | btf_nxt | stp_nxt | err_nxt | af_nxt;

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sr1_seen_r   <= 1'b0;
      rxd_seen_r   <= 1'b0;
      tx_full_r    <= 1'b0;
      rel_pend_r   <= 1'b0;
      stop_req_d_r <= 1'b0;
      OWN_ADDRESS_HIT <= 1'b0;
      BYTE_DONE_FLAG  <= 1'b0;
      STOP_SEEN_FLAG  <= 1'b0;
      MISPLACED_CONDITION_ERROR <= 1'b0;
      NACK_SEEN_FLAG  <= 1'b0;
      EVENT_PENDING   <= 1'b0;
      IRQ             <= 1'b0;
      CONTROLLER_ROLE_BIT <= 1'b0;
      TRANSMIT_ROLE   <= 1'b0;
      BUS_BUSY        <= 1'b0;
      SDA_OUT         <= 1'b0;
      SCL_OUT         <= 1'b0;
      SDA_OE          <= 1'b0;
      SCL_OE          <= 1'b0;
    end
    else if (CE)
    begin
      stop_req_d_r <= STOP_REQ;
      // a read arriving as the hold opens still counts for that hold
      sr1_seen_r <= SR1_RD | (sr1_seen_r & ~enter_hold & ~leave_hold);
      rxd_seen_r <= RXD_RD | (rxd_seen_r & ~enter_hold & ~leave_hold);
      tx_full_r  <= TXD_WR | (tx_full_r & ~(leave_hold & dir_tx_r));
      rel_pend_r <= PE & ((stop_req_d_r & ~STOP_REQ & BYTE_DONE_FLAG) |
                          (rel_pend_r & ~(sst_r == S_HOLD)));
      OWN_ADDRESS_HIT <= PE & adr_nxt;
      BYTE_DONE_FLAG  <= PE & btf_nxt;
      STOP_SEEN_FLAG  <= PE & stp_nxt;
      MISPLACED_CONDITION_ERROR <= PE & err_nxt;
      NACK_SEEN_FLAG  <= PE & af_nxt;
      EVENT_PENDING   <= PE & evt_nxt;
      IRQ             <= PE & evt_nxt & IRQ_ENABLE & BUS_IRQ_MASK;
      CONTROLLER_ROLE_BIT <= PE && !arb_lost &&
                             (mst_r == M_ON || mst_r == M_STOP1 || mst_r == M_STOP2);
      TRANSMIT_ROLE   <= PE & dir_tx_r & (sst_r == S_TX || sst_r == S_TXACK ||
                                          (sst_r == S_HOLD && dir_tx_r));
      BUS_BUSY        <= PE & (cond_start | (BUS_BUSY & ~cond_stop));
      SDA_OE          <= PE & (s_sda_low_r | m_sda_low_r);
      SCL_OE          <= PE & (s_scl_low_r | m_scl_low_r);
    end
  end
endmodule // ibs_core
`default_nettype wire

//--- hw/ibs_regs.vh
// constants for the two-wire bus interface: serial clock divider timing and slave path
`ifndef IBS_REGS_VH
`define IBS_REGS_VH
// ****************************************************************
// timing
// ****************************************************************
`define IBS_CLK_PERIOD_NS    25
`define IBS_STD_HALF_NS      5000
`define IBS_FAST_HALF_NS     1250
`define IBS_STD_HALF_CYC     ((`IBS_STD_HALF_NS) / (`IBS_CLK_PERIOD_NS))
`define IBS_FAST_HALF_CYC    ((`IBS_FAST_HALF_NS) / (`IBS_CLK_PERIOD_NS))
// ****************************************************************
// address matching
// ****************************************************************
`define IBS_HDR10_PREFIX     5'h1E
`define IBS_GEN_CALL_ADDR    8'h00
`define IBS_RESET_BYTE       8'h00
`endif

//--- hw/ibs_scl_div.v
// programmable half-period tick generator for the serial clock
`default_nettype none
`include "ibs_regs.vh"
module ibs_scl_div #(
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          nrst,
  input  wire          ce,
  input  wire          run,
  input  wire          fast,
  input  wire [CW-1:0] div_std,
  input  wire [CW-1:0] div_fast,
  output reg           tick
);
  // a zero setting falls back to the nominal rate of the selected mode
  localparam [CW-1:0] STD_LIM  = `IBS_STD_HALF_CYC;
  localparam [CW-1:0] FAST_LIM = `IBS_FAST_HALF_CYC;
  reg  [CW-1:0] cnt_r;
  wire [CW-1:0] sel;
  wire [CW-1:0] lim;
  assign sel = fast ? div_fast : div_std;
  assign lim = (sel != {CW{1'b0}}) ? sel : (fast ? FAST_LIM : STD_LIM);

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= {CW{1'b0}};
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      tick <= 1'b0;
      if (!run)
        cnt_r <= {CW{1'b0}};
      else if (cnt_r + 1'b1 >= lim)
      begin
        cnt_r <= {CW{1'b0}};
        tick  <= 1'b1;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // ibs_scl_div
`default_nettype wire
